// ===== logic/sfd_pkg.sv
// Package with the constants and carrier types of the special function space.
package sfd_pkg;

    // Bus address layout: word address bits carry the location index.
    localparam int PADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;
    localparam int ADDR_INDIRECT_BIT = 10;
    localparam int ADDR_BITOP_BIT = 11;

    // Bit-operation write data layout.
    localparam int BITOP_SEL_LSB = 0;
    localparam int BITOP_SEL_W = 3;
    localparam int BITOP_VAL_BIT = 3;

    // Location indexes; the bus byte address is four times the index.
    localparam logic [7:0] IDX_P0 = 8'h80;
    localparam logic [7:0] IDX_SP = 8'h81;
    localparam logic [7:0] IDX_DPL = 8'h82;
    localparam logic [7:0] IDX_DPH = 8'h83;
    localparam logic [7:0] IDX_DPL1 = 8'h84;
    localparam logic [7:0] IDX_DPH1 = 8'h85;
    localparam logic [7:0] IDX_PSEL = 8'h86;
    localparam logic [7:0] IDX_TCON = 8'h88;
    localparam logic [7:0] IDX_CKCON = 8'h8E;
    localparam logic [7:0] IDX_P1 = 8'h90;
    localparam logic [7:0] IDX_SBUF0 = 8'h99;
    localparam logic [7:0] IDX_P2 = 8'hA0;
    localparam logic [7:0] IDX_P3 = 8'hB0;
    localparam logic [7:0] IDX_SBUF1 = 8'hC1;
    localparam logic [7:0] IDX_T2CON = 8'hC8;
    localparam logic [7:0] IDX_TL [3] = '{8'h8A, 8'h8B, 8'hCC};
    localparam logic [7:0] IDX_TH [3] = '{8'h8C, 8'h8D, 8'hCD};
    localparam logic [7:0] IDX_PORT [4] = '{8'h80, 8'h90, 8'hA0, 8'hB0};

    // Pointer select register fields.
    localparam int PSEL_ACT = 0;
    localparam int PSEL_ADJ = 4;
    localparam int PSEL_TGL = 5;
    localparam int PSEL_DEC0 = 6;
    localparam logic [7:0] PSEL_WMASK = 8'hF1;

    // Timer control fields.
    localparam int TCON_TR0 = 4;
    localparam int TCON_TR1 = 6;
    localparam int T2CON_TR2 = 2;
    localparam int CKCON_T0M = 3;

    // Reset values.
    localparam logic [7:0] RST_PORT = 8'hFF;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_PSEL = 8'h04;
    localparam logic [7:0] RST_CKCON = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Timer timing: input clocks per increment in the compatible mode.
    localparam int TIMER_SLOW_DIV = 12;
    localparam int TIMER_W = 16;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } sfd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sfd_apb_rsp_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sfd_rx_t;

endpackage

// ===== logic/sfd_timer.sv
// One 16-bit timer/counter with a selectable 12-clock or 1-clock increment.
`timescale 1ns/1ps
module sfd_timer #(
    parameter int DIV = 12,
    parameter int W = 16
) (
    input wire logic pclk, // Core clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic run, // Counting enabled.
    input wire logic fast, // One increment per clock when high.
    input wire logic wr_lo, // Software write of the low byte.
    input wire logic wr_hi, // Software write of the high byte.
    input wire logic [7:0] wdata, // Byte written by software.
    output logic [W-1:0] count // Current count.
);
    localparam int PW = $clog2(DIV);
    localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);

    logic [PW-1:0] pre_reg;
    logic [PW-1:0] pre_next;
    logic [W-1:0] count_next;
    logic tick;

    // The prescaler only runs in slow mode, so a switch to slow mode
    // always starts from a whole period of twelve clocks.
    always_comb begin
        pre_next = pre_reg;
        count_next = count;
        tick = fast || (pre_reg == PRE_LAST);
        if (run && !fast) begin
            pre_next = (pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
        end else if (fast) begin
            pre_next = '0;
        end
        if (run && tick) begin
            count_next = count + 1'b1;
        end
        // A software write wins over the increment in the same clock.
        if (wr_lo) begin
            count_next[7:0] = wdata;
        end
        if (wr_hi) begin
            count_next[15:8] = wdata;
        end
    end

    // Registered timer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
            count <= '0;
        end else begin
            pre_reg <= pre_next;
            count <= count_next;
        end
    end
endmodule

// ===== logic/sfd_space.sv
// Special function register space with dual data pointers, on APB.
// Function
// - Space covers indexes 80h to FFh, reachable by direct access only.
// - Single-bit access allowed only where index low nibble is 0h or 8h.
// - Two data pointers; the active one addresses external data moves.
// - Select bit 0 of pointer select register chooses the active pointer.
// - Select bit 5 set toggles the active pointer after each use.
// - Automatic adjust increments or decrements the active pointer on use.
// - Stack pointer holds top entry; software may load any value.
// - Four 8-bit port latches, readable and writable, keep last write.
// - Three 16-bit timers, each byte its own readable, writable location.
// - Timers count once per 12 clocks after reset, or once per clock.
// - Each serial port uses one data location; access type picks direction.
// - One machine cycle per clock: a pointer use completes each clock.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sfd_space (
    input wire logic pclk, // Core clock, 200 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire sfd_pkg::sfd_apb_req_t apb_req, // APB request signals.
    output sfd_pkg::sfd_apb_rsp_t apb_rsp, // APB answer signals.
    input wire logic xdm_req, // External data move uses the pointer.
    output logic [15:0] xdm_addr, // Address from the active pointer.
    output logic [3:0][7:0] port_latch, // Port output latches.
    input wire sfd_pkg::sfd_rx_t rx0, // Received byte from serial port 0.
    input wire sfd_pkg::sfd_rx_t rx1, // Received byte from serial port 1.
    output logic [1:0][7:0] tx_data, // Bytes loaded for transmission.
    output logic [1:0] tx_load // One-cycle pulse per transmit load.
);
    import sfd_pkg::*;

    // Bus decode signals.
    logic setup;
    logic access;
    logic [IDX_W-1:0] idx;
    logic indirect;
    logic bitop;
    logic [BITOP_SEL_W-1:0] bit_sel;
    logic acc_err;
    logic [7:0] cur;
    sfd_apb_rsp_t rsp_next;

    // Write strobe toward the register state.
    logic wr_en;
    logic [7:0] wbyte;

    // Register state.
    logic [7:0] sp_reg;
    logic [7:0] sp_next;
    logic [15:0] ptr_reg [2];
    logic [15:0] ptr_next [2];
    logic [7:0] psel_reg;
    logic [7:0] psel_next;
    logic [7:0] tcon_reg;
    logic [7:0] tcon_next;
    logic [7:0] t2con_reg;
    logic [7:0] t2con_next;
    logic [7:0] ckcon_reg;
    logic [7:0] ckcon_next;
    logic [3:0][7:0] port_next;
    logic [7:0] rx_hold_reg [2];
    logic [7:0] rx_hold_next [2];
    logic [1:0][7:0] tx_data_next;
    logic [1:0] tx_load_next;
    logic [15:0] xdm_addr_next;
    sfd_rx_t rx_in [2];

    // Timer interface.
    logic [15:0] tcount [3];
    logic [2:0] t_run;
    logic [2:0] t_wr_lo;
    logic [2:0] t_wr_hi;

    // True where the location accepts single-bit access.
    function automatic logic bit_ok(input logic [7:0] i);
        bit_ok = (i[3:0] == 4'h0) || (i[3:0] == 4'h8);
    endfunction

    // Read value of a location; unimplemented locations read as zero.
    function automatic logic [7:0] rd_sfr(input logic [7:0] i);
        logic [7:0] v;
        v = RST_ZERO;
        case (i)
            IDX_SP: v = sp_reg;
            IDX_DPL: v = ptr_reg[0][7:0];
            IDX_DPH: v = ptr_reg[0][15:8];
            IDX_DPL1: v = ptr_reg[1][7:0];
            IDX_DPH1: v = ptr_reg[1][15:8];
            IDX_PSEL: v = psel_reg;
            IDX_TCON: v = tcon_reg;
            IDX_T2CON: v = t2con_reg;
            IDX_CKCON: v = ckcon_reg;
            IDX_SBUF0: v = rx_hold_reg[0];
            IDX_SBUF1: v = rx_hold_reg[1];
            default: v = RST_ZERO;
        endcase
        for (int k = 0; k < 4; k++) begin
            if (i == IDX_PORT[k]) begin
                v = port_latch[k];
            end
        end
        for (int k = 0; k < 3; k++) begin
            if (i == IDX_TL[k]) begin
                v = tcount[k][7:0];
            end
            if (i == IDX_TH[k]) begin
                v = tcount[k][15:8];
            end
        end
        rd_sfr = v;
    endfunction

    // Decode of the request. A request below index 80h or flagged as an
    // indirect access gets an error, since the space is direct-only.
    always_comb begin
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && apb_rsp.pready;
        idx = apb_req.paddr[IDX_LSB +: IDX_W];
        indirect = apb_req.paddr[ADDR_INDIRECT_BIT];
        bitop = apb_req.paddr[ADDR_BITOP_BIT];
        bit_sel = apb_req.pwdata[BITOP_SEL_LSB +: BITOP_SEL_W];
        acc_err = indirect || !idx[7];
        if (bitop && !bit_ok(idx)) begin
            acc_err = 1'b1;
        end
        cur = rd_sfr(idx);
        wr_en = access && apb_req.pwrite && !acc_err;
        wbyte = apb_req.pwdata[7:0];
        if (bitop) begin
            // Bit write is a read-modify-write of the whole location.
            wbyte = cur;
            wbyte[bit_sel] = apb_req.pwdata[BITOP_VAL_BIT];
        end
    end

    // Answer: ready follows every setup cycle, so each transfer has
    // exactly one access cycle. Read data is captured at setup.
    always_comb begin
        rsp_next.pready = setup;
        rsp_next.pslverr = setup && acc_err;
        rsp_next.prdata = '0;
        if (setup && !acc_err && !apb_req.pwrite) begin
            if (bitop) begin
                rsp_next.prdata = {31'h0, cur[bit_sel]};
            end else begin
                rsp_next.prdata = {24'h0, cur};
            end
        end
    end

    // Bus answer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_rsp <= '0;
        end else begin
            apb_rsp <= rsp_next;
        end
    end

    // Serial inputs gathered for indexing.
    always_comb begin
        rx_in[0] = rx0;
        rx_in[1] = rx1;
    end

    // Pointer group. A use adjusts and toggles first; a software write
    // to the same byte in the same clock then overrides the use, so
    // software reads back what it wrote, except in the unused select bits.
    always_comb begin
        logic act;
        act = psel_reg[PSEL_ACT];
        ptr_next = ptr_reg;
        psel_next = psel_reg;
        // Each pointer use completes in one clock.
        if (xdm_req && psel_reg[PSEL_ADJ]) begin
            if (psel_reg[PSEL_DEC0 + int'(act)]) begin
                ptr_next[act] = ptr_reg[act] - 16'h0001;
            end else begin
                ptr_next[act] = ptr_reg[act] + 16'h0001;
            end
        end
        if (xdm_req && psel_reg[PSEL_TGL]) begin
            psel_next[PSEL_ACT] = !psel_reg[PSEL_ACT];
        end
        if (wr_en) begin
            case (idx)
                IDX_DPL: ptr_next[0][7:0] = wbyte;
                IDX_DPH: ptr_next[0][15:8] = wbyte;
                IDX_DPL1: ptr_next[1][7:0] = wbyte;
                IDX_DPH1: ptr_next[1][15:8] = wbyte;
                IDX_PSEL: begin
                    // Unused bits keep their reset value.
                    psel_next = (psel_reg & ~PSEL_WMASK)
                        | (wbyte & PSEL_WMASK);
                end
                default: begin
                end
            endcase
        end
        // The address shows the pointer that will be active next clock,
        // so a data move never waits for the select to settle.
        xdm_addr_next = ptr_next[psel_next[PSEL_ACT]];
    end

    // Pointer registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg[0] <= '0;
            ptr_reg[1] <= '0;
            psel_reg <= RST_PSEL;
            xdm_addr <= '0;
        end else begin
            ptr_reg <= ptr_next;
            psel_reg <= psel_next;
            xdm_addr <= xdm_addr_next;
        end
    end

    // Stack pointer and timer control group. The stack pointer is a
    // plain byte here; pushes and pops belong to the core.
    always_comb begin
        sp_next = sp_reg;
        tcon_next = tcon_reg;
        t2con_next = t2con_reg;
        ckcon_next = ckcon_reg;
        if (wr_en) begin
            case (idx)
                IDX_SP: sp_next = wbyte;
                IDX_TCON: tcon_next = wbyte;
                IDX_T2CON: t2con_next = wbyte;
                IDX_CKCON: ckcon_next = wbyte;
                default: begin
                end
            endcase
        end
    end

    // Control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= RST_SP;
            tcon_reg <= RST_ZERO;
            t2con_reg <= RST_ZERO;
            ckcon_reg <= RST_CKCON;
        end else begin
            sp_reg <= sp_next;
            tcon_reg <= tcon_next;
            t2con_reg <= t2con_next;
            ckcon_reg <= ckcon_next;
        end
    end

    // Port latch group. The latch holds what software wrote, not the
    // level on the pin, so a read returns the written value.
    always_comb begin
        port_next = port_latch;
        for (int k = 0; k < 4; k++) begin
            if (wr_en && (idx == IDX_PORT[k])) begin
                port_next[k] = wbyte;
            end
        end
    end

    // Port latch registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_latch <= {4{RST_PORT}};
        end else begin
            port_latch <= port_next;
        end
    end

    // Serial group. Receive and transmit share one index per port; the
    // access direction picks the holder, so a write never disturbs a
    // received byte still waiting to be read.
    always_comb begin
        rx_hold_next = rx_hold_reg;
        tx_data_next = tx_data;
        tx_load_next = '0;
        for (int k = 0; k < 2; k++) begin
            if (rx_in[k].valid) begin
                rx_hold_next[k] = rx_in[k].data;
            end
        end
        if (wr_en && (idx == IDX_SBUF0)) begin
            tx_data_next[0] = wbyte;
            tx_load_next[0] = 1'b1;
        end
        if (wr_en && (idx == IDX_SBUF1)) begin
            tx_data_next[1] = wbyte;
            tx_load_next[1] = 1'b1;
        end
    end

    // Serial registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hold_reg[0] <= RST_ZERO;
            rx_hold_reg[1] <= RST_ZERO;
            tx_data <= '0;
            tx_load <= '0;
        end else begin
            rx_hold_reg <= rx_hold_next;
            tx_data <= tx_data_next;
            tx_load <= tx_load_next;
        end
    end

    // Timer controls: run bits and per-byte write strobes.
    always_comb begin
        t_run[0] = tcon_reg[TCON_TR0];
        t_run[1] = tcon_reg[TCON_TR1];
        t_run[2] = t2con_reg[T2CON_TR2];
        for (int k = 0; k < 3; k++) begin
            t_wr_lo[k] = wr_en && (idx == IDX_TL[k]);
            t_wr_hi[k] = wr_en && (idx == IDX_TH[k]);
        end
    end

    // Three timers; the speed bit of each clears to the 12-clock mode.
    for (genvar g = 0; g < 3; g++) begin : g_tmr
        sfd_timer #(
            .DIV(TIMER_SLOW_DIV),
            .W(TIMER_W)
        ) u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .run(t_run[g]),
            .fast(ckcon_reg[CKCON_T0M + g]),
            .wr_lo(t_wr_lo[g]),
            .wr_hi(t_wr_hi[g]),
            .wdata(wbyte),
            .count(tcount[g])
        );
    end
endmodule

// ===== testbench/sfd_space_sva.sv
// Checker of the special function space port behaviour.
`timescale 1ns/1ps
module sfd_space_sva (
    input wire logic pclk, // Core clock.
    input wire logic presetn, // Reset, active low.
    input wire sfd_pkg::sfd_apb_req_t apb_req, // Bus request.
    input wire sfd_pkg::sfd_apb_rsp_t apb_rsp, // Bus answer.
    input wire logic xdm_req, // Pointer use.
    input wire logic [15:0] xdm_addr, // Active pointer.
    input wire logic [3:0][7:0] port_latch, // Port latches.
    input wire logic [1:0][7:0] tx_data, // Transmit bytes.
    input wire logic [1:0] tx_load // Transmit pulses.
);
    import sfd_pkg::*;
    logic setup;
    logic acc;
    logic wacc;
    logic [7:0] idx;
    // Decoded views of the request keep the properties short.
    assign setup = apb_req.psel && !apb_req.penable;
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wacc = acc && apb_req.pwrite && !apb_rsp.pslverr;
    assign idx = apb_req.paddr[IDX_LSB+:IDX_W];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready;
        setup |=> apb_rsp.pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_ready_cause;
        apb_rsp.pready |-> $past(setup);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("stray ready");
    property p_low;
        setup && idx < 8'h80 |=> apb_rsp.pslverr;
    endproperty
    a_low: assert property (p_low) else $error("low index taken");
    property p_ind;
        setup && apb_req.paddr[ADDR_INDIRECT_BIT] |=> apb_rsp.pslverr;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect taken");
    property p_bit;
        setup && idx >= 8'h80 && !apb_req.paddr[ADDR_INDIRECT_BIT]
            && apb_req.paddr[ADDR_BITOP_BIT]
            |=> apb_rsp.pslverr == (idx[2:0] != 3'h0);
    endproperty
    a_bit: assert property (p_bit) else $error("bit access wrong");
    property p_tx;
        wacc && idx == IDX_SBUF0
            |=> tx_load[0] && tx_data[0] == $past(apb_req.pwdata[7:0]);
    endproperty
    a_tx: assert property (p_tx) else $error("tx load wrong");
    property p_txq;
        tx_load[1] |-> $past(wacc && idx == IDX_SBUF1);
    endproperty
    a_txq: assert property (p_txq) else $error("stray tx load");
    property p_port;
        !(acc && idx == IDX_P0) |=> $stable(port_latch[0]);
    endproperty
    a_port: assert property (p_port) else $error("port moved");
    property p_ptr;
        !xdm_req && !acc |=> $stable(xdm_addr);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer moved");
    property p_tx1;
        wacc && idx == IDX_SBUF1
            |=> tx_load[1] && tx_data[1] == $past(apb_req.pwdata[7:0]);
    endproperty
    a_tx1: assert property (p_tx1) else $error("tx1 load wrong");
    property p_err;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error answer wrong");
endmodule

bind sfd_space sfd_space_sva u_sva (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .xdm_req(xdm_req),
    .xdm_addr(xdm_addr), .port_latch(port_latch), .tx_data(tx_data),
    .tx_load(tx_load));

// ===== testbench/tb_sfd_space.sv
// Self-checking bench of the special function space over APB.
`timescale 1ns/1ps
module tb_sfd_space;
    import sfd_pkg::*;
    logic pclk;
    logic presetn;
    logic xdm_req;
    sfd_apb_req_t req;
    sfd_apb_rsp_t rsp;
    sfd_rx_t rx0;
    sfd_rx_t rx1;
    logic [15:0] xdm_addr;
    logic [3:0][7:0] port_latch;
    logic [1:0][7:0] tx_data;
    logic [1:0] tx_load;
    logic [31:0] rd;
    logic er;
    int mismatches;
    int checks;
    int cyc;
    logic [7:0] sbuf [2] = '{IDX_SBUF0, IDX_SBUF1};

    sfd_space dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .xdm_req(xdm_req), .xdm_addr(xdm_addr),
        .port_latch(port_latch), .rx0(rx0), .rx1(rx1), .tx_data(tx_data),
        .tx_load(tx_load));

    // Clock at 200 MHz.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Hang guard; the whole run needs well under two thousand cycles.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready is sampled high
    // at a rising edge. One idle clock follows, so the next call never
    // rewrites psel in the time step that released it.
    task automatic xfer(input logic w, input logic [1:0] m,
        input logic [7:0] i, input logic [31:0] d);
        req <= '{1'b1, 1'b0, w, {m, i, 2'b00}, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, 2'b00, i, {24'h0, d});
    endtask

    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        xfer(1'b0, 2'b00, i, 32'h0);
        chk(rd, {24'h0, e});
        chk(er, 0);
    endtask

    task automatic pchk(input logic [15:0] e);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(xdm_addr, e);
        @(posedge pclk);
    endtask

    task automatic use_ptr(input int n, input logic [15:0] e);
        xdm_req <= 1'b1;
        repeat (n) @(posedge pclk);
        xdm_req <= 1'b0;
        pchk(e);
    endtask

    // Runs timer 0 for a fixed stretch and bounds the count reached.
    task automatic run_t0(input int lo, input int hi);
        wr(IDX_TL[0], 8'h00);
        wr(IDX_TCON, 8'h10);
        repeat (120) @(posedge pclk);
        wr(IDX_TCON, 8'h00);
        xfer(1'b0, 2'b00, IDX_TL[0], 32'h0);
        chk(rd >= lo && rd <= hi, 1);
    endtask

    // Main sequence.
    initial begin
        presetn = 1'b0;
        req = '0;
        xdm_req = 1'b0;
        rx0 = '0;
        rx1 = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rchk(IDX_SP, RST_SP);
        rchk(IDX_PSEL, RST_PSEL);
        rchk(IDX_DPH1, RST_ZERO);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            rchk(IDX_PORT[i], RST_PORT);
            wr(IDX_PORT[i], 8'h3C + i[7:0]);
            rchk(IDX_PORT[i], 8'h3C + i[7:0]);
            chk(port_latch[i], 8'h3C + i[7:0]);
        end
        xfer(1'b1, 2'b10, IDX_P1, 32'h2);
        rchk(IDX_P1, 8'h39);
        xfer(1'b0, 2'b10, IDX_P1, 32'h0);
        chk(rd, 1);
        wr(IDX_SP, 8'hC3);
        xfer(1'b1, 2'b10, IDX_SP, 32'h8);
        chk(er, 1);
        rchk(IDX_SP, 8'hC3);
        $display("port test done");
        xfer(1'b1, 2'b01, IDX_P0, 32'h0);
        chk(er, 1);
        chk(port_latch[0], 8'h3C);
        xfer(1'b0, 2'b00, 8'h7F, 32'h0);
        chk(er, 1);
        rchk(8'hF0, 8'h00);
        $display("decode test done");
        wr(IDX_DPL, 8'hFE);
        wr(IDX_DPH, 8'h12);
        wr(IDX_DPL1, 8'h10);
        wr(IDX_DPH1, 8'h20);
        wr(IDX_PSEL, 8'h10);
        use_ptr(2, 16'h1300);
        rchk(IDX_DPH, 8'h13);
        wr(IDX_PSEL, 8'h31);
        pchk(16'h2010);
        use_ptr(1, 16'h1300);
        use_ptr(1, 16'h2011);
        wr(IDX_PSEL, 8'hD1);
        use_ptr(1, 16'h2010);
        wr(IDX_PSEL, 8'h50);
        use_ptr(1, 16'h1300);
        wr(IDX_PSEL, 8'h00);
        pchk(16'h1300);
        rchk(IDX_PSEL, 8'h04);
        $display("pointer test done");
        for (int i = 0; i < 3; i++) begin
            wr(IDX_TL[i], 8'h50 + i[7:0]);
            wr(IDX_TH[i], 8'hA0 + i[7:0]);
            rchk(IDX_TL[i], 8'h50 + i[7:0]);
            rchk(IDX_TH[i], 8'hA0 + i[7:0]);
        end
        run_t0(9, 11);
        wr(IDX_CKCON, 8'h08);
        run_t0(120, 124);
        $display("timer test done");
        for (int i = 0; i < 2; i++) begin
            if (i == 0) begin
                rx0 <= '{1'b1, 8'h5A};
            end else begin
                rx1 <= '{1'b1, 8'h5B};
            end
            @(posedge pclk);
            rx0 <= '0;
            rx1 <= '0;
            wr(sbuf[i], 8'hA5);
            chk(tx_data[i], 8'hA5);
            rchk(sbuf[i], (i == 0) ? 8'h5A : 8'h5B);
        end
        $display("serial test done");
        conclude();
    end
endmodule
